// ### logic/regulator_pkg.sv
// Constants and types shared by the regulator power mode selection logic.
package regulator_pkg;

   // APB register map, byte addresses.
   localparam logic [11:0] ADDR_REGULATOR_CONTROL = 12'h000;
   localparam logic [11:0] ADDR_REGULATOR_STATUS  = 12'h004;
   localparam logic [11:0] ADDR_CONDITION_STATUS  = 12'h008;

   // Regulator control register layout.
   localparam int          CTRL_RESERVED_BIT = 0;
   localparam int          CTRL_SAVE_SEL_BIT = 1;
   localparam int          CTRL_WIDTH        = 8;
   localparam logic [7:0]  CTRL_RESET        = 8'h01;
   localparam logic [7:0]  CTRL_WRITE_MASK   = 8'h03;

   // Oscillator selection codes.
   localparam logic [2:0]  OSC_SEL_EXT       = 3'h0;
   localparam logic [2:0]  OSC_SEL_16MHZ     = 3'h1;
   localparam logic [2:0]  OSC_SEL_8MHZ      = 3'h2;
   localparam logic [2:0]  OSC_SEL_4MHZ      = 3'h3;
   localparam logic [2:0]  OSC_SEL_1MHZ      = 3'h4;
   localparam logic [2:0]  OSC_SEL_500KHZ    = 3'h5;
   localparam logic [2:0]  OSC_SEL_250KHZ    = 3'h6;
   localparam logic [2:0]  OSC_SEL_31KHZ     = 3'h7;

   // Encoded regulator mode presented at the output.
   localparam logic [1:0]  MODE_HIGH         = 2'h0;
   localparam logic [1:0]  MODE_LOW          = 2'h1;
   localparam logic [1:0]  MODE_POWER_SAVE   = 2'h2;
   localparam logic [1:0]  MODE_TRACKING     = 2'h3;

   // Status register fields.
   localparam int          STAT_MODE_LSB     = 0;
   localparam int          STAT_BIAS_LSB     = 2;

   typedef enum logic [1:0] {
      BIAS_HIGH,
      BIAS_MEDIUM,
      BIAS_LOW
   } bias_type;

endpackage : regulator_pkg

// ### logic/regulator_mode_decode.sv
// Combinational decode of the regulator power mode from its conditions.
module regulator_mode_decode (
   input  wire logic       i_sleeping,
   input  wire logic [2:0] i_osc_sel,
   input  wire logic       i_save_select,
   input  wire logic       i_brownout_reset_en,
   input  wire logic       i_hfosc_periph_active,
   input  wire logic       i_self_write_active,
   input  wire logic       i_adc_converting,
   input  wire logic       i_supply_low,
   output logic      [1:0] o_mode,
   output logic      [1:0] o_bias
);

   regulator_pkg::bias_type bias;
   logic                    force_low;

   always_comb begin
      unique case (i_osc_sel)
         regulator_pkg::OSC_SEL_EXT,
         regulator_pkg::OSC_SEL_16MHZ: begin
            bias = regulator_pkg::BIAS_HIGH;
         end
         regulator_pkg::OSC_SEL_8MHZ,
         regulator_pkg::OSC_SEL_4MHZ,
         regulator_pkg::OSC_SEL_1MHZ: begin
            bias = regulator_pkg::BIAS_MEDIUM;
         end
         regulator_pkg::OSC_SEL_500KHZ,
         regulator_pkg::OSC_SEL_250KHZ,
         regulator_pkg::OSC_SEL_31KHZ: begin
            bias = regulator_pkg::BIAS_LOW;
         end
      endcase
   end

   assign force_low = i_brownout_reset_en | i_hfosc_periph_active |
                      i_self_write_active | i_adc_converting;

   always_comb begin
      o_bias = bias;
      if (i_supply_low) begin
         o_mode = regulator_pkg::MODE_TRACKING;
      end else if (!i_sleeping) begin
         if (bias == regulator_pkg::BIAS_LOW) begin
            o_mode = regulator_pkg::MODE_LOW;
         end else begin
            o_mode = regulator_pkg::MODE_HIGH;
         end
      end else if (i_save_select && !force_low) begin
         o_mode = regulator_pkg::MODE_POWER_SAVE;
      end else begin
         o_mode = regulator_pkg::MODE_LOW;
      end
   end

endmodule // regulator_mode_decode

// ### logic/regulator_power_mode_select.sv
// Regulator power mode selection with its APB control register.
//
// Our own choices: the APB interface to the registers and the address map.

// Overview of operation
// - Awake with high bias gives High mode.
// - Awake with medium bias gives High mode.
// - Awake with low bias gives Low mode.
// - Sleep, save select clear gives Low mode.
// - Sleep, save select set, idle gives Power-Save.
// - Forcing conditions override Power-Save to Low.
// - Low supply selects Tracking mode automatically.
// - Save select is bit 1, resets zero.
// - Bit 0 reserved, resets one, keep set.
// - Upper six bits read zero, ignore writes.
module regulator_power_mode_select (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        i_sleeping,
   input  wire logic [2:0]  i_osc_sel,
   input  wire logic        i_brownout_reset_en,
   input  wire logic        i_hfosc_periph_active,
   input  wire logic        i_self_write_active,
   input  wire logic        i_adc_converting,
   input  wire logic        i_supply_low,
   output logic      [1:0]  o_regulator_mode,
   output logic             o_sleep_power_save_select
);

   logic [7:0]  regulator_control_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic [1:0]  mode_r;
   logic [1:0]  mode_nxt;
   logic [1:0]  bias_nxt;
   logic [1:0]  bias_r;
   logic [1:0]  supply_low_sync_r;
   logic [31:0] read_value;
   logic        addr_ok;
   logic        setup;

   // Supply comparator is analog and asynchronous, so it is synchronised.
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         supply_low_sync_r <= 2'h0;
      end else begin
         supply_low_sync_r <= {supply_low_sync_r[0], i_supply_low};
      end
   end

   regulator_mode_decode u_decode (
      .i_sleeping            (i_sleeping),
      .i_osc_sel             (i_osc_sel),
      .i_save_select         (regulator_control_r[
                                 regulator_pkg::CTRL_SAVE_SEL_BIT]),
      .i_brownout_reset_en   (i_brownout_reset_en),
      .i_hfosc_periph_active (i_hfosc_periph_active),
      .i_self_write_active   (i_self_write_active),
      .i_adc_converting      (i_adc_converting),
      .i_supply_low          (supply_low_sync_r[1]),
      .o_mode                (mode_nxt),
      .o_bias                (bias_nxt)
   );

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         mode_r <= regulator_pkg::MODE_HIGH;
         bias_r <= 2'h0;
      end else begin
         mode_r <= mode_nxt;
         bias_r <= bias_nxt;
      end
   end

   assign setup   = psel && !penable;
   assign addr_ok = (paddr == regulator_pkg::ADDR_REGULATOR_CONTROL) ||
                    (paddr == regulator_pkg::ADDR_REGULATOR_STATUS) ||
                    (paddr == regulator_pkg::ADDR_CONDITION_STATUS);

   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         regulator_control_r <= regulator_pkg::CTRL_RESET;
      end else if (psel && penable && pready_r && pwrite && pstrb[0] &&
                   paddr == regulator_pkg::ADDR_REGULATOR_CONTROL) begin
         regulator_control_r <= pwdata[7:0] &
                                regulator_pkg::CTRL_WRITE_MASK;
      end
   end

   always_comb begin
      read_value = 32'h0;
      unique case (paddr)
         regulator_pkg::ADDR_REGULATOR_CONTROL: begin
            read_value[7:0] = regulator_control_r &
                              regulator_pkg::CTRL_WRITE_MASK;
         end
         regulator_pkg::ADDR_REGULATOR_STATUS: begin
            read_value[regulator_pkg::STAT_MODE_LSB +: 2] = mode_r;
            read_value[regulator_pkg::STAT_BIAS_LSB +: 2] = bias_r;
         end
         regulator_pkg::ADDR_CONDITION_STATUS: begin
            read_value[5:0] = {supply_low_sync_r[1], i_adc_converting,
                               i_self_write_active, i_hfosc_periph_active,
                               i_brownout_reset_en, i_sleeping};
         end
         default: begin
            read_value = 32'h0;
         end
      endcase
   end

   // No wait states: ready rises in the first access cycle.
   always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end else if (setup) begin
         pready_r  <= 1'b1;
         pslverr_r <= !addr_ok;
         prdata_r  <= pwrite ? 32'h0 : read_value;
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end
   end

   assign prdata                    = prdata_r;
   assign pready                    = pready_r;
   assign pslverr                   = pslverr_r;
   assign o_regulator_mode          = mode_r;
   assign o_sleep_power_save_select =
      regulator_control_r[regulator_pkg::CTRL_SAVE_SEL_BIT];

   chk_tracking_on_low: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      supply_low_sync_r[1]
      |=> o_regulator_mode == 2'h3)
      else $error("Tracking not entered on low supply.");

   chk_sleep_low_mode: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (i_sleeping && !o_sleep_power_save_select && !supply_low_sync_r[1])
      |=> o_regulator_mode == 2'h1)
      else $error("Sleep without save select not in Low mode.");

   chk_power_save_entry: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (i_sleeping && o_sleep_power_save_select && !supply_low_sync_r[1] &&
       !i_brownout_reset_en && !i_hfosc_periph_active &&
       !i_self_write_active && !i_adc_converting)
      |=> o_regulator_mode == 2'h2)
      else $error("Power-Save not selected in idle sleep.");

   chk_forced_low_mode: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (i_sleeping && !supply_low_sync_r[1] && (i_brownout_reset_en ||
       i_adc_converting || i_self_write_active || i_hfosc_periph_active))
      |=> o_regulator_mode == 2'h1)
      else $error("Forcing condition did not force Low mode.");

   chk_awake_high_mode: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (!i_sleeping && !supply_low_sync_r[1] && i_osc_sel <= 3'h4)
      |=> o_regulator_mode == 2'h0)
      else $error("Awake high or medium bias not High mode.");

   chk_awake_low_mode: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (!i_sleeping && !supply_low_sync_r[1] && i_osc_sel >= 3'h5)
      |=> o_regulator_mode == 2'h1)
      else $error("Awake low bias not Low mode.");

   chk_control_reset: assert property (
      @(posedge i_core_clk)
      !i_reset_n
      |=> regulator_control_r == 8'h01)
      else $error("Control register reset value wrong.");

   chk_upper_bits_zero: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      regulator_control_r[7:2] == 6'h0)
      else $error("Unimplemented control bits not zero.");

   chk_upper_read_zero: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (pready && !pwrite && paddr == 12'h000)
      |-> prdata[31:2] == 30'h0)
      else $error("Unimplemented control bits read nonzero.");

   chk_select_write: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h000)
      |=> o_sleep_power_save_select == $past(pwdata[1]))
      else $error("Save select write not taken.");

   chk_ready_after_setup: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (psel && !penable)
      |=> pready)
      else $error("Ready not raised in the access cycle.");

   chk_ready_single: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      pready
      |=> !pready)
      else $error("Ready held beyond one cycle.");

   chk_slverr_unmapped: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (psel && !penable &&
       paddr != regulator_pkg::ADDR_REGULATOR_CONTROL &&
       paddr != regulator_pkg::ADDR_REGULATOR_STATUS &&
       paddr != regulator_pkg::ADDR_CONDITION_STATUS)
      |=> pslverr)
      else $error("Unmapped address gave no error.");

   chk_slverr_with_ready: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      pslverr
      |-> pready)
      else $error("Error raised outside the ready cycle.");

   chk_rdata_idle_zero: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      !pready
      |-> prdata == 32'h0)
      else $error("Read data not zero outside the ready cycle.");

   chk_select_holds: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      !(psel && penable && pready && pwrite && pstrb[0] &&
        paddr == regulator_pkg::ADDR_REGULATOR_CONTROL)
      |=> $stable(o_sleep_power_save_select))
      else $error("Save select changed without a write.");

   chk_reserved_holds: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      !(psel && penable && pready && pwrite && pstrb[0] &&
        paddr == regulator_pkg::ADDR_REGULATOR_CONTROL)
      |=> $stable(regulator_control_r[
                     regulator_pkg::CTRL_RESERVED_BIT]))
      else $error("Reserved bit changed without a write.");

   chk_supply_sync_delay: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      i_supply_low [*3]
      |=> o_regulator_mode == regulator_pkg::MODE_TRACKING)
      else $error("Tracking late after a steady low supply.");

   chk_no_tracking_ok: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      !supply_low_sync_r[1]
      |=> o_regulator_mode != regulator_pkg::MODE_TRACKING)
      else $error("Tracking entered with supply in range.");

   chk_status_readback: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      (psel && !penable && !pwrite &&
       paddr == regulator_pkg::ADDR_REGULATOR_STATUS)
      |=> prdata[1:0] == $past(o_regulator_mode))
      else $error("Status read does not show the mode.");

   chk_awake_no_save: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      !i_sleeping
      |=> o_regulator_mode != regulator_pkg::MODE_POWER_SAVE)
      else $error("Power-Save selected while awake.");

   chk_save_needs_sleep: assert property (
      @(posedge i_core_clk)
      disable iff (!i_reset_n)
      o_regulator_mode == regulator_pkg::MODE_POWER_SAVE
      |-> $past(i_sleeping) && $past(o_sleep_power_save_select))
      else $error("Power-Save without sleep and select.");

   cov_power_save: cover property (
      @(posedge i_core_clk)
      o_regulator_mode == 2'h2);
   cov_tracking: cover property (
      @(posedge i_core_clk)
      o_regulator_mode == 2'h3);
   cov_forced: cover property (
      @(posedge i_core_clk)
      i_sleeping && o_sleep_power_save_select && i_adc_converting);
   cov_slverr: cover property (
      @(posedge i_core_clk)
      pslverr);
   cov_sleep_exit: cover property (
      @(posedge i_core_clk)
      $fell(i_sleeping));

endmodule // regulator_power_mode_select

// ### tb/regulator_power_mode_select_tb.sv
// Self-checking bench for the regulator power mode selection block.
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
   bad_count++; $display("[ERR] %s exp=%h got=%h", n, e, g); end end
module regulator_power_mode_select_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_core_clk = 1'b0;
   logic        i_reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        sleeping, bo, hf, sw, adc, low, sel, o_sel;
   logic [2:0]  osc;
   logic [1:0]  o_mode, bexp;
   int          bad_count, checks_done, cyc, waits;
   // Row: sleep, osc code, select, four forcing inputs, low supply, mode.
   logic [11:0] rows [19] = '{12'h000, 12'h100, 12'h200, 12'h300,
      12'h400, 12'h501, 12'h601, 12'h701, 12'h1c0, 12'h901, 12'hf01,
      12'h882, 12'hf82, 12'h9c1, 12'h9a1, 12'h991, 12'h989, 12'h107,
      12'h80f};

   regulator_power_mode_select u_dut (
      .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .i_sleeping(sleeping), .i_osc_sel(osc),
      .i_brownout_reset_en(bo), .i_hfosc_periph_active(hf),
      .i_self_write_active(sw), .i_adc_converting(adc),
      .i_supply_low(low), .o_regulator_mode(o_mode),
      .o_sleep_power_save_select(o_sel));

   always #25 i_core_clk = ~i_core_clk;

   // A hung handshake ends the run here rather than stalling forever.
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Entered just after an edge; returns at the edge that sampled pready.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_core_clk);
      penable <= 1'b1;
      waits = 0;
      do begin
         @(posedge i_core_clk);
         waits++;
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
   endtask

   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge i_core_clk);
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {sleeping, osc, sel, bo, hf, sw, adc, low} = '0;
      i_reset_n = 1'b0;
      repeat (12) @(posedge i_core_clk);
      `CHK("rst_mode", regulator_pkg::MODE_HIGH, o_mode)
      i_reset_n <= 1'b1;
      apb(1'b0, regulator_pkg::ADDR_REGULATOR_CONTROL, 32'h0);
      `CHK("rst_ctrl", 32'h1, rd)
      `CHK("ready", 1, waits)
      `CHK("rst_sel", 1'b0, o_sel)
      foreach (rows[k]) begin
         // Bit 0 is always written set, as software must keep it.
         apb(1'b1, regulator_pkg::ADDR_REGULATOR_CONTROL,
             32'hffff_fffc | {30'h0, rows[k][7], 1'b1});
         apb(1'b0, regulator_pkg::ADDR_REGULATOR_CONTROL, 32'h0);
         `CHK("ctrl", {30'h0, rows[k][7], 1'b1}, rd)
         idle();
         {sleeping, osc, sel, bo, hf, sw, adc, low} <= rows[k][11:2];
         // Low supply passes a two-stage synchroniser, so allow four edges.
         repeat (4) @(posedge i_core_clk);
         `CHK("mode", rows[k][1:0], o_mode)
         `CHK("mode", rows[k][1:0], o_mode)
         `CHK("mode", rows[k][1:0], o_mode)
         `CHK("sel", sel, o_sel)
         apb(1'b0, regulator_pkg::ADDR_REGULATOR_STATUS, 32'h0);
         `CHK("stat", rows[k][1:0], rd[1:0])
         bexp = (osc <= regulator_pkg::OSC_SEL_16MHZ) ? 2'h0 :
                (osc <= regulator_pkg::OSC_SEL_1MHZ) ? 2'h1 : 2'h2;
         `CHK("bias", bexp, rd[3:2])
         `CHK("ok_err", 1'b0, err)
         apb(1'b0, regulator_pkg::ADDR_CONDITION_STATUS, 32'h0);
         `CHK("cond", {26'h0, low, adc, sw, hf, bo, sleeping}, rd)
         idle();
      end
      apb(1'b1, 12'h00c, 32'hffff_ffff);
      `CHK("bad_wr", 1'b1, err)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("bad_rd", 32'h0, rd)
      `CHK("bad_rd", 1'b1, err)
      apb(1'b1, regulator_pkg::ADDR_REGULATOR_CONTROL, 32'hffff_fffd);
      apb(1'b0, regulator_pkg::ADDR_REGULATOR_CONTROL, 32'h0);
      `CHK("rsv_keep", 32'h1, rd)
      apb(1'b1, regulator_pkg::ADDR_REGULATOR_CONTROL, 32'h3);
      idle();
      i_reset_n <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      `CHK("rst2_sel", 1'b0, o_sel)
      i_reset_n <= 1'b1;
      apb(1'b0, regulator_pkg::ADDR_REGULATOR_CONTROL, 32'h0);
      `CHK("rst2_ctrl", 32'h1, rd)
      idle();
      final_report();
   end
endmodule // regulator_power_mode_select_tb
